// ==== rtl/hvb_addr_gen.sv ====
// Purpose: Forms handler and table-entry addresses from the base registers.
// Assumes: Inputs are register outputs; result is combinational.
// Notes: Low nine base bits are forced to zero whatever the register holds.
`timescale 1ns/1ps
module hvb_addr_gen
(
   input wire logic [31:0] exc_base,
   input wire logic [31:0] int_table,
   input wire logic base_select,
   input wire logic [8:0] exc_offset,
   input wire logic [11:0] channel,
   output logic [31:0] handler_addr,
   output logic [31:0] table_entry_addr
);
   wire logic [31:0] eff_base;
   wire logic [31:0] table_base;
   assign eff_base = base_select ? (exc_base & hvb_pkg::BASE_MASK)
      : hvb_pkg::DEFAULT_VECTOR_BASE; // RQ5 RQ7
   assign handler_addr = eff_base + {23'h000000, exc_offset}; // RQ6
   assign table_base = int_table & hvb_pkg::BASE_MASK; // RQ11 RQ12
   // Each table entry is one word, so the channel scales by four.
   assign table_entry_addr = table_base + {18'h00000, channel, 2'h0};
endmodule : hvb_addr_gen

// ==== rtl/hvb_core.sv ====
// Purpose: Host exception base, interrupt table base and protection id list registers.
// Assumes: Permit list is a static system strap, sampled every cycle; single clock.
// Notes: Base registers reset to zero here, though software must still initialise them.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
// Functional notes
// RQ1 - The list register shows 1 for each programmable identifier and 0 for each illegal one.
// RQ2 - The list comes from outside the CPU and CPU writes never change it.
// RQ3 - Identifier n maps to list bit n across all 32 bits.
// RQ4 - A write of an illegal identifier leaves the current identifier unchanged.
// RQ5 - The exception base applies only while base select is 1, else default vectors apply.
// RQ6 - A handler address is the base bits 31 to 9 plus the exception offset.
// RQ7 - The low nine exception base bits count as zero.
// RQ8 - Reserved bits read as zero and software writes zero to them.
// RQ9 - Base bit 1 selects direct-vector interrupt addressing over table reference.
// RQ10 - Base bit 0 selects the reduced set of interrupt handler addresses.
// RQ11 - Table reference uses table base bits 31 to 9 as the table start.
// RQ12 - The low nine table base bits are zero, aligning the table to 512 bytes.
// RQ13 - Software initialises both bases before enabling the modes that use them.
module hvb_core
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic [31:0] id_permit_bits,
   input wire logic base_select_bit,
   output logic [4:0] current_protection_id,
   output logic direct_vector_select,
   output logic reduced_vector_select,
   output logic [31:0] handler_address,
   output logic [31:0] table_entry_address
);
   logic [31:0] exc_base;
   logic [31:0] int_table;
   logic [4:0] cur_id;
   logic [31:0] permit_list;
   logic base_sel;
   logic [8:0] exc_offset;
   logic [11:0] channel;
   logic [31:0] rdata_q;
   logic [31:0] handler_q;
   logic [31:0] entry_q;
   wire logic [31:0] handler_comb;
   wire logic [31:0] entry_comb;
   wire logic hit_list;
   wire logic hit_exc;
   wire logic hit_tab;
   wire logic hit_id;
   wire logic hit_ctrl;
   wire logic hit_query;
   wire logic hit_hand;
   wire logic hit_entry;
   wire logic id_legal;
   wire logic [31:0] next_rdata;
   wire logic [31:0] ctrl_view;
   wire logic [31:0] query_view;

   assign hit_list = addr == hvb_pkg::OFS_PERMIT_LIST;
   assign hit_exc = addr == hvb_pkg::OFS_EXC_BASE;
   assign hit_tab = addr == hvb_pkg::OFS_INT_TABLE;
   assign hit_id = addr == hvb_pkg::OFS_CUR_ID;
   assign hit_ctrl = addr == hvb_pkg::OFS_CTRL;
   assign hit_query = addr == hvb_pkg::OFS_EXC_QUERY;
   assign hit_hand = addr == hvb_pkg::OFS_HANDLER;
   assign hit_entry = addr == hvb_pkg::OFS_TABLE_ENTRY;

   // The id is checked against the list bit it indexes.
   assign id_legal = permit_list[wdata[4:0]]; // RQ3 RQ4

   assign ctrl_view = {31'h00000000, base_sel};
   assign query_view = {11'h000, channel, exc_offset};

   assign next_rdata = hit_list ? permit_list // RQ1
      : hit_exc ? (exc_base & hvb_pkg::EXC_BASE_MASK) // RQ8
      : hit_tab ? (int_table & hvb_pkg::BASE_MASK) // RQ8
      : hit_id ? {27'h0000000, cur_id}
      : hit_ctrl ? ctrl_view
      : hit_query ? query_view
      : hit_hand ? handler_q
      : hit_entry ? entry_q
      : hvb_pkg::UNMAPPED_READ;

   hvb_addr_gen u_gen
   (
      .exc_base(exc_base),
      .int_table(int_table),
      .base_select(base_sel),
      .exc_offset(exc_offset),
      .channel(channel),
      .handler_addr(handler_comb),
      .table_entry_addr(entry_comb)
   );

   // The permit list has no write path; it follows the strap input only.
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         permit_list <= 32'h0000_0000;
      else
         permit_list <= id_permit_bits; // RQ2
   end

   // The reserved bits are stored as zero so the effective value is clean.
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         exc_base <= hvb_pkg::EXC_BASE_RESET;
      else if (wr && hit_exc)
         exc_base <= wdata & hvb_pkg::EXC_BASE_MASK; // RQ8
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         int_table <= hvb_pkg::INT_TABLE_RESET;
      else if (wr && hit_tab)
         int_table <= wdata & hvb_pkg::BASE_MASK; // RQ12
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         cur_id <= hvb_pkg::CUR_ID_RESET;
      else if (wr && hit_id && id_legal)
         cur_id <= wdata[4:0]; // RQ4
   end

   // Base select follows the status input, and a software override register
   // is not provided: the pin is the only source, the control word mirrors it.
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         base_sel <= 1'b0;
      else
         base_sel <= base_select_bit; // RQ5
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         exc_offset <= 9'h000;
         channel <= 12'h000;
      end
      else if (wr && hit_query)
      begin
         exc_offset <= wdata[8:0];
         channel <= wdata[20:9];
      end
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         handler_q <= 32'h0000_0000;
         entry_q <= 32'h0000_0000;
      end
      else
      begin
         handler_q <= handler_comb; // RQ6
         entry_q <= entry_comb; // RQ11
      end
   end

   // Read data stands only in the cycle after the strobe.
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         rdata_q <= 32'h0000_0000;
      else if (rd)
         rdata_q <= next_rdata;
      else
         rdata_q <= 32'h0000_0000;
   end

   assign rdata = rdata_q;
   assign current_protection_id = cur_id;
   assign direct_vector_select = exc_base[hvb_pkg::DIRECT_VEC_BIT]; // RQ9
   assign reduced_vector_select = exc_base[hvb_pkg::REDUCED_VEC_BIT]; // RQ10
   assign handler_address = handler_q;
   assign table_entry_address = entry_q;
endmodule : hvb_core

// ==== rtl/hvb_pkg.sv ====
// Purpose: Shared constants for the host vector base and protection id list block.
// Assumes: Plain register port with 32-bit data and word-aligned byte addresses.
// Notes: Register offsets are local choices; no offsets are printed for these registers.
package hvb_pkg;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned ID_W = 5;
   localparam logic [7:0] OFS_PERMIT_LIST = 8'h00;
   localparam logic [7:0] OFS_EXC_BASE = 8'h04;
   localparam logic [7:0] OFS_INT_TABLE = 8'h08;
   localparam logic [7:0] OFS_CUR_ID = 8'h0C;
   localparam logic [7:0] OFS_CTRL = 8'h10;
   localparam logic [7:0] OFS_EXC_QUERY = 8'h14;
   localparam logic [7:0] OFS_HANDLER = 8'h18;
   localparam logic [7:0] OFS_TABLE_ENTRY = 8'h1C;
   localparam int unsigned BASE_LSB = 9;
   localparam int unsigned DIRECT_VEC_BIT = 1;
   localparam int unsigned REDUCED_VEC_BIT = 0;
   localparam int unsigned OFFSET_W = 9;
   localparam int unsigned CHAN_W = 12;
   localparam logic [31:0] BASE_MASK = 32'hFFFF_FE00;
   localparam logic [31:0] EXC_BASE_MASK = 32'hFFFF_FE03;
   localparam logic [31:0] DEFAULT_VECTOR_BASE = 32'h0000_0000;
   localparam logic [31:0] EXC_BASE_RESET = 32'h0000_0000;
   localparam logic [31:0] INT_TABLE_RESET = 32'h0000_0000;
   localparam logic [4:0] CUR_ID_RESET = 5'h00;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage : hvb_pkg

// ==== tb/hvb_core_assertions.sv ====
// Purpose: Port-level checks on the vector base and permit list registers.
// Assumes: The permit strap stays steady while the block runs.
// Notes: Bound to every hvb_core below the module.
`timescale 1ns/1ps
module hvb_core_assertions
(
   input logic clock,
   input logic rstn,
   input logic [7:0] addr,
   input logic [31:0] wdata,
   input logic wr,
   input logic rd,
   input logic [31:0] rdata,
   input logic [31:0] id_permit_bits,
   input logic base_select_bit,
   input logic [4:0] current_protection_id,
   input logic direct_vector_select,
   input logic reduced_vector_select,
   input logic [31:0] handler_address,
   input logic [31:0] table_entry_address
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   property p_perm; rd && addr == 8'h00 |=> rdata == $past(id_permit_bits); endproperty
   a_perm: assert property (p_perm) else $error("permit list read");
   property p_id_skip; wr && addr == 8'h0C && !id_permit_bits[wdata[4:0]] |=>
      $stable(current_protection_id); endproperty
   a_id_skip: assert property (p_id_skip) else $error("illegal id taken");
   property p_id_take; wr && addr == 8'h0C && id_permit_bits[wdata[4:0]] |=>
      current_protection_id == 5'($past(wdata)); endproperty
   a_id_take: assert property (p_id_take) else $error("legal id lost");
   property p_vec; wr && addr == 8'h04 |=>
      {direct_vector_select, reduced_vector_select} == 2'($past(wdata)); endproperty
   a_vec: assert property (p_vec) else $error("vector select bits");
   property p_exc_rsv; rd && addr == 8'h04 |=> rdata[8:2] == 7'h00; endproperty
   a_exc_rsv: assert property (p_exc_rsv) else $error("base reserved bits");
   property p_tab_rsv; rd && addr == 8'h08 |=> rdata[8:0] == 9'h000; endproperty
   a_tab_rsv: assert property (p_tab_rsv) else $error("table low bits");
   property p_dflt; !base_select_bit [*3] |-> handler_address[31:9] == 23'h0; endproperty
   a_dflt: assert property (p_dflt) else $error("default vector");
   property p_idle; !$past(rd) |-> rdata == 32'h0000_0000; endproperty
   a_idle: assert property (p_idle) else $error("stray read data");
   c_skip: cover property (wr && addr == 8'h0C && !id_permit_bits[wdata[4:0]]);
   c_sel: cover property (base_select_bit [*3]);
   c_tab: cover property (rd && addr == 8'h08);
endmodule : hvb_core_assertions
bind hvb_core hvb_core_assertions hvb_core_assertions_i (.clock(clock), .rstn(rstn),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .id_permit_bits(id_permit_bits), .base_select_bit(base_select_bit),
   .current_protection_id(current_protection_id), .direct_vector_select(direct_vector_select),
   .reduced_vector_select(reduced_vector_select), .handler_address(handler_address),
   .table_entry_address(table_entry_address));

// ==== tb/hvb_core_bench.sv ====
// Purpose: Directed bench for the vector base and permit list registers.
// Assumes: Static permit strap; register port answers reads one cycle later.
// Notes: Base registers are written before their modes are used.
`timescale 1ns/1ps
module hvb_core_bench;
   localparam logic [31:0] STRAP = 32'hA000_0005;
   logic clock = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, base_select_bit = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, handler_address, table_entry_address;
   logic [4:0] current_protection_id;
   logic direct_vector_select, reduced_vector_select;
   int fail_count = 0, checked = 0;
   always #2 clock = ~clock;
   hvb_core hvb_core_i (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .id_permit_bits(STRAP), .base_select_bit(base_select_bit),
      .current_protection_id(current_protection_id), .direct_vector_select(direct_vector_select),
      .reduced_vector_select(reduced_vector_select), .handler_address(handler_address),
      .table_entry_address(table_entry_address));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         $display("Error %0t got %h exp %h", $time, got, exp);
         fail_count++;
      end
   endtask : chk
   // A trailing idle edge keeps a strobe from being lowered and raised in one step.
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
      @(posedge clock);
   endtask : bus_wr
   task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 chk(rdata, exp);
      @(posedge clock);
   endtask : bus_rd
   task automatic t_id;
      bus_wr(8'h00, 32'hFFFF_FFFF);
      bus_rd(8'h00, STRAP);
      bus_rd(8'h40, 32'h0000_0000);
      bus_wr(8'h0C, 32'h0000_001F);
      bus_wr(8'h0C, 32'h0000_0001);
      #1 chk({27'h0, current_protection_id}, 32'h0000_001F);
      @(posedge clock);
      bus_wr(8'h0C, 32'h0000_0000);
      bus_rd(8'h0C, 32'h0000_0000);
   endtask : t_id
   task automatic t_base;
      bus_wr(8'h04, 32'hFFFF_FFFF);
      bus_rd(8'h04, 32'hFFFF_FE03);
      chk({30'h0, direct_vector_select, reduced_vector_select}, 32'h3);
      bus_wr(8'h04, 32'h1234_56FE);
      bus_wr(8'h14, 32'h0000_01FF);
      base_select_bit <= 1'b1;
      repeat (3) @(posedge clock);
      #1 chk(handler_address, 32'h1234_57FF);
      chk({30'h0, direct_vector_select, reduced_vector_select}, 32'h2);
      @(posedge clock);
      bus_rd(8'h10, 32'h0000_0001);
      base_select_bit <= 1'b0;
      repeat (3) @(posedge clock);
      bus_rd(8'h18, 32'h0000_01FF);
      bus_wr(8'h08, 32'hFFFF_FFFF);
      bus_rd(8'h08, 32'hFFFF_FE00);
      bus_wr(8'h14, 32'h0000_0600);
      #1 chk(table_entry_address, 32'hFFFF_FE0C);
   endtask : t_base
   task automatic end_sim;
      if (fail_count == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_sim
   initial
   begin
      repeat (3) @(posedge clock);
      rstn <= 1'b1;
      repeat (2) @(posedge clock);
      t_id();
      t_base();
      end_sim();
   end
   initial
   begin
      #20000;
      fail_count++;
      end_sim();
   end
endmodule : hvb_core_bench
